// ==== inc/eprom_cfg_pkg.sv ====
`default_nettype none
package eprom_cfg_pkg;
   // Code-space addresses
   localparam logic [15:0] SIG_ADDR_0 = 16'hfc30;
   localparam logic [15:0] SIG_ADDR_1 = 16'hfc31;
   localparam logic [15:0] SIG_ADDR_2 = 16'hfc60;
   localparam logic [15:0] CUST_BASE = 16'hffe0 & 16'hfce0;
   localparam logic [15:0] CUST_LAST = 16'hfcff;
   localparam int CUST_DEPTH = 32;
   // External-data addresses of the configuration bytes
   localparam logic [15:0] CFG1_XADDR = 16'hfd00;
   localparam logic [15:0] CFG2_XADDR = 16'hfd01;
   // Bit positions in byte one
   localparam int WDT_BIT = 7;
   localparam int RPD_BIT = 6;
   localparam int PRT_BIT = 5;
   localparam int BOV_BIT = 4;
   localparam int CYC_BIT = 3;
   // Unprogrammed values and reset values
   localparam logic [7:0] CFG_ERASED = 8'hff;
   localparam logic [7:0] SIG_RESET = 8'h00;
   // Programming commands
   localparam logic [3:0] CMD_WR_CODE = 4'h1;
   localparam logic [3:0] CMD_RD_CODE = 4'h2;
   localparam logic [3:0] CMD_WR_CFG1 = 4'h3;
   localparam logic [3:0] CMD_WR_CFG2 = 4'h4;
   localparam logic [3:0] CMD_WR_SB1 = 4'h5;
   localparam logic [3:0] CMD_WR_SB2 = 4'h6;
   localparam int FRAME_BITS = 28;
   localparam logic [4:0] FRAME_LAST = 5'h1b;
   localparam logic [3:0] READ_LAST = 4'h7;

   typedef enum logic [2:0]
   {
      CLK_HF = 3'h0,
      CLK_MF = 3'h1,
      CLK_LF = 3'h2,
      CLK_RC = 3'h3,
      CLK_EXT = 3'h7
   } clk_src_e;

   typedef struct packed
   {
      logic wdt_reset_en;
      logic reset_pin_off;
      logic port_reset_high;
      logic brownout_low;
      logic cycle_12clk;
      logic [2:0] clk_sel;
      logic clk_valid;
   } cfg_decode_s;

   typedef struct packed
   {
      logic [3:0] cmd;
      logic [15:0] addr;
      logic [7:0] data;
   } prog_frame_s;
endpackage
`default_nettype wire

// ==== logic/cfg_byte_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfg_byte_decode
(
   // Byte one as latched
   input wire logic [7:0] i_cfg,
   // Decoded features
   output eprom_cfg_pkg::cfg_decode_s o_dec
);
   always_comb
   begin
      o_dec.wdt_reset_en = i_cfg[eprom_cfg_pkg::WDT_BIT];
      o_dec.reset_pin_off = i_cfg[eprom_cfg_pkg::RPD_BIT];
      o_dec.port_reset_high = i_cfg[eprom_cfg_pkg::PRT_BIT];
      o_dec.brownout_low = i_cfg[eprom_cfg_pkg::BOV_BIT];
      // cycle length, one is 12 clocks
      o_dec.cycle_12clk = i_cfg[eprom_cfg_pkg::CYC_BIT];
      o_dec.clk_sel = i_cfg[2:0];
      case (i_cfg[2:0])
         eprom_cfg_pkg::CLK_EXT, eprom_cfg_pkg::CLK_RC, eprom_cfg_pkg::CLK_LF,
         eprom_cfg_pkg::CLK_MF, eprom_cfg_pkg::CLK_HF:
            o_dec.clk_valid = 1'b1;
         default:
            o_dec.clk_valid = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ==== logic/eprom_cfg_security.sv ====
// Contract
// - Programming traffic runs serially on two pins, both ways, once in programming mode.
// - Three read-only signature bytes answer code-space reads at three fixed addresses.
// - A 32-byte customer area in code space returns its contents to code-space reads.
// - The programmer writes the customer area in the same session as code and config.
// - Both config bytes are latched at power up and software cannot change them.
// - Software reads both config bytes by external-data reads at fixed addresses.
// - Byte one bit 7 at zero disables watchdog reset; the timer may still interrupt.
// - Byte one bit 6 at one makes the reset pin an input-only port pin.
// - Byte one bit 5 selects ports resetting high (1) or low (0).
// - Byte one bit 4 at one picks the lower brownout level, at zero the higher.
// - With no security bit programmed the programmer may verify code.
// - With only security bit one programmed all programming is refused but bit two.
// - With both security bits programmed programming and verify are refused.
`timescale 1ns/1ps
`default_nettype none
module eprom_cfg_security
#(
   parameter int CODE_AW = 10,
   parameter logic [7:0] SIG_BYTE_0 = 8'h15, // Arbitrary identity
   parameter logic [7:0] SIG_BYTE_1 = 8'h2a, // Arbitrary identity
   parameter logic [7:0] SIG_BYTE_2 = 8'h3c  // Arbitrary identity
)
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Power-up latch of stored configuration
   input wire logic i_pwr_up_load,
   input wire logic [7:0] i_nv_cfg1,
   input wire logic [7:0] i_nv_cfg2,
   // CPU read port
   input wire logic i_code_rd,
   input wire logic i_xdata_rd,
   input wire logic [15:0] i_cpu_addr,
   output logic [7:0] o_cpu_rdata,
   output logic o_cpu_hit,
   // Serial programming pins
   input wire logic i_prog_mode,
   input wire logic i_pclk,
   input wire logic i_pdat_in,
   output logic o_pdat_out,
   output logic o_pdat_oe,
   // Code memory write port and verify read data
   output logic o_code_we,
   output logic [15:0] o_code_addr,
   output logic [7:0] o_code_wdata,
   input wire logic [7:0] i_code_rdata,
   // Configuration features
   output logic [7:0] o_power_up_config_byte_one,
   output logic [7:0] o_power_up_config_byte_two,
   output logic o_wdt_reset_en,
   output logic o_reset_pin_off,
   output logic o_port_reset_high,
   output logic o_brownout_low,
   output logic o_cycle_12clk,
   output logic [2:0] o_clk_sel,
   output logic o_clk_sel_valid,
   output logic o_security_bit_one,
   output logic o_security_bit_two,
   output logic o_prog_refused
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_READ = 3'b100
   } prog_state_e;

   function automatic logic in_cust(input logic [15:0] a);
      in_cust = (a >= eprom_cfg_pkg::CUST_BASE) &&
                (a <= eprom_cfg_pkg::CUST_LAST);
   endfunction

   logic [7:0] cust_mem [eprom_cfg_pkg::CUST_DEPTH];
   logic [7:0] cfg1_q, cfg1_d, cfg2_q, cfg2_d;
   logic [7:0] nv1_q, nv1_d, nv2_q, nv2_d;
   logic sb1_q, sb1_d, sb2_q, sb2_d;
   logic [7:0] rdata_q, rdata_d;
   logic hit_q, hit_d;
   prog_state_e st_q, st_d;
   logic [27:0] sh_q, sh_d;
   logic [4:0] cnt_q, cnt_d;
   logic pclk_q, pclk_d;
   logic [7:0] rd_sh_q, rd_sh_d;
   logic dout_q, dout_d, doe_q, doe_d;
   logic we_q, we_d;
   logic [15:0] waddr_q, waddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic refused_q, refused_d;
   logic cust_we;
   logic [4:0] cust_idx;
   eprom_cfg_pkg::cfg_decode_s dec;
   eprom_cfg_pkg::prog_frame_s frm;
   logic rise;
   logic fall;

   cfg_byte_decode u_dec
   (
      .i_cfg(cfg1_q),
      .o_dec(dec)
   );

   ////////////////////////////////////////////////////////////////////////
   // CPU reads
   always_comb
   begin
      rdata_d = 8'h00;
      hit_d = 1'b0;
      if (i_code_rd)
      begin
         if (i_cpu_addr == eprom_cfg_pkg::SIG_ADDR_0)
         begin
            rdata_d = SIG_BYTE_0;
            hit_d = 1'b1;
         end
         else if (i_cpu_addr == eprom_cfg_pkg::SIG_ADDR_1)
         begin
            rdata_d = SIG_BYTE_1;
            hit_d = 1'b1;
         end
         else if (i_cpu_addr == eprom_cfg_pkg::SIG_ADDR_2)
         begin
            rdata_d = SIG_BYTE_2;
            hit_d = 1'b1;
         end
         else if (in_cust(i_cpu_addr))
         begin
            rdata_d = cust_mem[i_cpu_addr[4:0]];
            hit_d = 1'b1;
         end
      end
      else if (i_xdata_rd)
      begin
         if (i_cpu_addr == eprom_cfg_pkg::CFG1_XADDR)
         begin
            rdata_d = cfg1_q;
            hit_d = 1'b1;
         end
         else if (i_cpu_addr == eprom_cfg_pkg::CFG2_XADDR)
         begin
            rdata_d = cfg2_q;
            hit_d = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial programming engine
   always_comb
   begin
      pclk_d = i_pclk;
      rise = i_pclk & ~pclk_q;
      fall = ~i_pclk & pclk_q;
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      rd_sh_d = rd_sh_q;
      dout_d = dout_q;
      doe_d = 1'b0;
      we_d = 1'b0;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      refused_d = refused_q;
      nv1_d = nv1_q;
      nv2_d = nv2_q;
      sb1_d = sb1_q;
      sb2_d = sb2_q;
      frm = sh_q;
      cust_we = 1'b0;
      cust_idx = 5'h00;
      case (st_q)
         ST_IDLE:
         begin
            cnt_d = 5'h00;
            if (i_prog_mode)
               st_d = ST_SHIFT;
         end
         ST_SHIFT:
         begin
            if (rise)
            begin
               sh_d = {sh_q[26:0], i_pdat_in};
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == eprom_cfg_pkg::FRAME_LAST)
               begin
                  frm = {sh_q[26:0], i_pdat_in};
                  cnt_d = 5'h00;
                  refused_d = 1'b0;
                  case (frm.cmd)
                     eprom_cfg_pkg::CMD_RD_CODE:
                        if (!sb1_q && !sb2_q)
                           refused_d = 1'b1;
                        else
                        begin
                           waddr_d = frm.addr;
                           st_d = ST_READ;
                        end
                     eprom_cfg_pkg::CMD_WR_SB2:
                        sb2_d = 1'b0;
                     default:
                        if (!sb1_q)
                           refused_d = 1'b1;
                        else
                        begin
                           case (frm.cmd)
                              eprom_cfg_pkg::CMD_WR_CODE:
                              begin
                                 if (in_cust(frm.addr))
                                 begin
                                    cust_we = 1'b1;
                                    cust_idx = frm.addr[4:0];
                                 end
                                 else
                                 begin
                                    we_d = 1'b1;
                                    waddr_d = frm.addr;
                                    wdata_d = frm.data;
                                 end
                              end
                              eprom_cfg_pkg::CMD_WR_CFG1:
                                 nv1_d = nv1_q & frm.data;
                              eprom_cfg_pkg::CMD_WR_CFG2:
                                 nv2_d = nv2_q & frm.data;
                              eprom_cfg_pkg::CMD_WR_SB1:
                                 sb1_d = 1'b0;
                              default:
                                 refused_d = 1'b1;
                           endcase
                        end
                  endcase
               end
            end
            if (!i_prog_mode)
               st_d = ST_IDLE;
         end
         ST_READ:
         begin
            doe_d = 1'b1;
            if (cnt_q == 5'h00 && !rise)
               rd_sh_d = in_cust(waddr_q) ? cust_mem[waddr_q[4:0]]
                                          : i_code_rdata;
            if (rise && cnt_q[3:0] != eprom_cfg_pkg::READ_LAST + 4'h1)
            begin
               dout_d = rd_sh_q[7];
               rd_sh_d = {rd_sh_q[6:0], 1'b0};
               cnt_d = cnt_q + 5'h01;
            end
            // Hold the pin through the last high phase of the clock
            if (fall && cnt_q[3:0] == eprom_cfg_pkg::READ_LAST + 4'h1)
            begin
               cnt_d = 5'h00;
               st_d = ST_SHIFT;
            end
            if (!i_prog_mode)
               st_d = ST_IDLE;
         end
         default:
            st_d = ST_IDLE;
      endcase
   end

   always_comb
   begin
      cfg1_d = cfg1_q;
      cfg2_d = cfg2_q;
      if (i_pwr_up_load)
      begin
         cfg1_d = i_nv_cfg1 & nv1_q;
         cfg2_d = i_nv_cfg2 & nv2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_mclk)
   begin
      if (cust_we)
         cust_mem[cust_idx] <= frm.data;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cfg1_q <= eprom_cfg_pkg::CFG_ERASED;
         cfg2_q <= eprom_cfg_pkg::CFG_ERASED;
         nv1_q <= eprom_cfg_pkg::CFG_ERASED;
         nv2_q <= eprom_cfg_pkg::CFG_ERASED;
         sb1_q <= 1'b1;
         sb2_q <= 1'b1;
         rdata_q <= eprom_cfg_pkg::SIG_RESET;
         hit_q <= 1'b0;
         st_q <= ST_IDLE;
         sh_q <= 28'h0000000;
         cnt_q <= 5'h00;
         pclk_q <= 1'b0;
         rd_sh_q <= 8'h00;
         dout_q <= 1'b0;
         doe_q <= 1'b0;
         we_q <= 1'b0;
         waddr_q <= 16'h0000;
         wdata_q <= 8'h00;
         refused_q <= 1'b0;
      end
      else
      begin
         cfg1_q <= cfg1_d;
         cfg2_q <= cfg2_d;
         nv1_q <= nv1_d;
         nv2_q <= nv2_d;
         sb1_q <= sb1_d;
         sb2_q <= sb2_d;
         rdata_q <= rdata_d;
         hit_q <= hit_d;
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         pclk_q <= pclk_d;
         rd_sh_q <= rd_sh_d;
         dout_q <= dout_d;
         doe_q <= doe_d;
         we_q <= we_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         refused_q <= refused_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoded outputs registered
   eprom_cfg_pkg::cfg_decode_s dec_q;
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         dec_q <= '1;
      else
         dec_q <= dec;
   end

   assign o_cpu_rdata = rdata_q;
   assign o_cpu_hit = hit_q;
   assign o_pdat_out = dout_q;
   assign o_pdat_oe = doe_q;
   assign o_code_we = we_q;
   assign o_code_addr = waddr_q;
   assign o_code_wdata = wdata_q;
   assign o_power_up_config_byte_one = cfg1_q;
   assign o_power_up_config_byte_two = cfg2_q;
   assign o_wdt_reset_en = dec_q.wdt_reset_en;
   assign o_reset_pin_off = dec_q.reset_pin_off;
   assign o_port_reset_high = dec_q.port_reset_high;
   assign o_brownout_low = dec_q.brownout_low;
   assign o_cycle_12clk = dec_q.cycle_12clk;
   assign o_clk_sel = dec_q.clk_sel;
   assign o_clk_sel_valid = dec_q.clk_valid;
   assign o_security_bit_one = sb1_q;
   assign o_security_bit_two = sb2_q;
   assign o_prog_refused = refused_q;
endmodule
`default_nettype wire

// ==== tb/eprom_cfg_security_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module eprom_cfg_security_sva
#(
   parameter logic [7:0] SIG_BYTE_0 = 8'h15, // Arbitrary identity
   parameter logic [7:0] SIG_BYTE_2 = 8'h3c  // Arbitrary identity
)
(
   // Clock, reset and stimulus
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_pwr_up_load,
   input wire logic i_code_rd,
   input wire logic i_xdata_rd,
   input wire logic [15:0] i_cpu_addr,
   input wire logic i_prog_mode,
   // Observed outputs
   input wire logic [7:0] o_cpu_rdata,
   input wire logic o_cpu_hit,
   input wire logic o_pdat_oe,
   input wire logic o_code_we,
   input wire logic [7:0] o_power_up_config_byte_one,
   input wire logic [7:0] o_power_up_config_byte_two,
   input wire logic o_wdt_reset_en,
   input wire logic o_reset_pin_off,
   input wire logic o_port_reset_high,
   input wire logic o_brownout_low,
   input wire logic o_cycle_12clk,
   input wire logic [2:0] o_clk_sel,
   input wire logic o_clk_sel_valid,
   input wire logic o_security_bit_one,
   input wire logic o_security_bit_two
);
   default clocking dclk @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   ////////////////////////////////////////////////////////////////////////
   sequence code_sig0;
      i_code_rd && !i_xdata_rd && i_cpu_addr == eprom_cfg_pkg::SIG_ADDR_0;
   endsequence
   sequence code_sig2;
      i_code_rd && !i_xdata_rd && i_cpu_addr == eprom_cfg_pkg::SIG_ADDR_2;
   endsequence
   sequence code_cust;
      i_code_rd && !i_xdata_rd && i_cpu_addr >= 16'hfce0 &&
         i_cpu_addr <= 16'hfcff;
   endsequence
   sequence xdata_cfg1;
      i_xdata_rd && !i_code_rd && !i_pwr_up_load &&
         i_cpu_addr == eprom_cfg_pkg::CFG1_XADDR;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   chk_sig_zero: assert property (code_sig0 |=> o_cpu_hit &&
      o_cpu_rdata == SIG_BYTE_0) else $error("signature 0 read wrong");
   chk_sig_two: assert property (code_sig2 |=> o_cpu_hit &&
      o_cpu_rdata == SIG_BYTE_2) else $error("signature 2 read wrong");
   chk_cust_hit: assert property (code_cust |=> o_cpu_hit)
      else $error("customer area read missed");
   chk_idle_miss: assert property (!i_code_rd && !i_xdata_rd
      |=> !o_cpu_hit) else $error("hit without a read");
   chk_cfg_xread: assert property (xdata_cfg1 |=> o_cpu_hit &&
      o_cpu_rdata == o_power_up_config_byte_one)
      else $error("config byte read wrong");
   chk_cfg_frozen: assert property (!i_pwr_up_load |=>
      $stable(o_power_up_config_byte_one) &&
      $stable(o_power_up_config_byte_two))
      else $error("config changed without load");
   chk_decode_bits: assert property ({o_wdt_reset_en,
      o_reset_pin_off, o_port_reset_high, o_brownout_low, o_cycle_12clk,
      o_clk_sel} == $past(o_power_up_config_byte_one))
      else $error("decoded features differ from byte");
   chk_clk_valid: assert property (o_clk_sel_valid ==
      ($past(o_power_up_config_byte_one[2:0]) inside
      {3'h0, 3'h1, 3'h2, 3'h3, 3'h7})) else $error("clock code validity");
   chk_write_lock: assert property (!o_security_bit_one |->
      !o_code_we) else $error("write while locked");
   chk_verify_lock: assert property (!o_security_bit_one &&
      !o_security_bit_two |-> !o_pdat_oe) else $error("verify while locked");
   chk_mode_idle: assert property (!i_prog_mode [*2] |->
      !o_pdat_oe && !o_code_we) else $error("activity outside mode");
endmodule

bind eprom_cfg_security eprom_cfg_security_sva
#(.SIG_BYTE_0(SIG_BYTE_0), .SIG_BYTE_2(SIG_BYTE_2)) u_sva
(
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pwr_up_load(i_pwr_up_load),
   .i_code_rd(i_code_rd), .i_xdata_rd(i_xdata_rd),
   .i_cpu_addr(i_cpu_addr), .i_prog_mode(i_prog_mode),
   .o_cpu_rdata(o_cpu_rdata), .o_cpu_hit(o_cpu_hit),
   .o_pdat_oe(o_pdat_oe), .o_code_we(o_code_we),
   .o_power_up_config_byte_one(o_power_up_config_byte_one),
   .o_power_up_config_byte_two(o_power_up_config_byte_two),
   .o_wdt_reset_en(o_wdt_reset_en), .o_reset_pin_off(o_reset_pin_off),
   .o_port_reset_high(o_port_reset_high),
   .o_brownout_low(o_brownout_low), .o_cycle_12clk(o_cycle_12clk),
   .o_clk_sel(o_clk_sel), .o_clk_sel_valid(o_clk_sel_valid),
   .o_security_bit_one(o_security_bit_one),
   .o_security_bit_two(o_security_bit_two)
);
`default_nettype wire

// ==== tb/prog_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module prog_host
(
   // Device side
   input wire logic i_mclk,
   input wire logic i_pdat_out,
   input wire logic i_pdat_oe,
   // Serial pins toward device
   output logic o_pclk,
   output logic o_pdat
);
   // Four clocks a level, above the one the sampler needs
   localparam int HALF = 4;

   initial
   begin
      o_pclk = 1'b0;
      o_pdat = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic pulse(output logic s, output logic e);
      repeat (HALF) @(negedge i_mclk);
      o_pclk = 1'b1;
      repeat (HALF) @(negedge i_mclk);
      s = i_pdat_out;
      e = i_pdat_oe;
      o_pclk = 1'b0;
   endtask

   task automatic send_frame(input eprom_cfg_pkg::prog_frame_s f);
      logic s;
      logic e;
      for (int i = eprom_cfg_pkg::FRAME_BITS - 1; i >= 0; i--)
      begin
         o_pdat = f[i];
         pulse(s, e);
      end
      // Inverse idle level so a stale bit is never read as valid
      o_pdat = ~f[0];
      repeat (2 * HALF) @(negedge i_mclk);
   endtask

   task automatic read_byte(output logic [7:0] b, output logic oe_all);
      logic s;
      logic e;
      oe_all = 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
         pulse(s, e);
         b[i] = s;
         oe_all = oe_all & e;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/eprom_cfg_security_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module eprom_cfg_security_test;
   localparam logic [7:0] SIG0 = 8'h61; // Arbitrary identity
   localparam logic [7:0] SIG1 = 8'h72; // Arbitrary identity
   localparam logic [7:0] SIG2 = 8'h83; // Arbitrary identity
   localparam logic [7:0] TBL [8] = '{8'h00, 8'h19, 8'h2a, 8'hc3,
      8'h54, 8'ha5, 8'h96, 8'hff};
   logic mclk, rst_n, load, crd, xrd, pmode;
   logic [7:0] nv1, nv2;
   logic [15:0] addr;
   logic [7:0] mem [0:1023];
   wire [7:0] rdata, cwdata, cfg1, cfg2;
   wire [15:0] caddr;
   wire hit, pclk, pdin, pdout, pdoe, cwe, val, sb1, sb2, refused;
   wire [2:0] csel;
   wire [4:0] dec;
   int err_count = 0;
   int total_checks = 0;

   eprom_cfg_security #(.SIG_BYTE_0(SIG0), .SIG_BYTE_1(SIG1),
      .SIG_BYTE_2(SIG2)) dut
   (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_pwr_up_load(load),
      .i_nv_cfg1(nv1), .i_nv_cfg2(nv2), .i_code_rd(crd),
      .i_xdata_rd(xrd), .i_cpu_addr(addr), .o_cpu_rdata(rdata),
      .o_cpu_hit(hit), .i_prog_mode(pmode), .i_pclk(pclk),
      .i_pdat_in(pdin), .o_pdat_out(pdout), .o_pdat_oe(pdoe),
      .o_code_we(cwe), .o_code_addr(caddr), .o_code_wdata(cwdata),
      .i_code_rdata(mem[caddr[9:0]]),
      .o_power_up_config_byte_one(cfg1),
      .o_power_up_config_byte_two(cfg2), .o_wdt_reset_en(dec[4]),
      .o_reset_pin_off(dec[3]), .o_port_reset_high(dec[2]),
      .o_brownout_low(dec[1]), .o_cycle_12clk(dec[0]), .o_clk_sel(csel),
      .o_clk_sel_valid(val), .o_security_bit_one(sb1),
      .o_security_bit_two(sb2), .o_prog_refused(refused)
   );
   prog_host host (.i_mclk(mclk), .i_pdat_out(pdout), .i_pdat_oe(pdoe),
      .o_pclk(pclk), .o_pdat(pdin));

   always #20 mclk = ~mclk;
   always @(posedge mclk)
      if (cwe)
         mem[caddr[9:0]] <= cwdata;

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (err_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd_chk(input logic code, input logic [15:0] a,
      input logic [7:0] exp, input logic exp_hit, input string what);
      crd = code;
      xrd = ~code;
      addr = a;
      @(negedge mclk);
      crd = 1'b0;
      xrd = 1'b0;
      cmp(what, exp, rdata);
      cmp({what, " hit"}, {7'h0, exp_hit}, {7'h0, hit});
   endtask

   task automatic power_up();
      load = 1'b1;
      @(negedge mclk);
      load = 1'b0;
      repeat (2) @(negedge mclk);
   endtask

   task automatic frame(input logic [3:0] c, input logic [15:0] a,
      input logic [7:0] d);
      eprom_cfg_pkg::prog_frame_s f;
      f = '{cmd: c, addr: a, data: d};
      host.send_frame(f);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_signature();
      rd_chk(1'b1, eprom_cfg_pkg::SIG_ADDR_0, SIG0, 1'b1, "sig0");
      rd_chk(1'b1, eprom_cfg_pkg::SIG_ADDR_1, SIG1, 1'b1, "sig1");
      rd_chk(1'b1, eprom_cfg_pkg::SIG_ADDR_2, SIG2, 1'b1, "sig2");
      rd_chk(1'b0, eprom_cfg_pkg::SIG_ADDR_0, 8'h00, 1'b0, "xsig");
      rd_chk(1'b1, 16'hfc32, 8'h00, 1'b0, "gap");
   endtask

   task automatic t_config();
      logic [7:0] v;
      logic ok;
      for (int i = 0; i < 8; i++)
      begin
         v = TBL[i];
         ok = v[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
         nv1 = v;
         nv2 = ~v;
         power_up();
         cmp("cfg1", v, cfg1);
         cmp("decode", v, {dec, csel});
         cmp("valid", {7'h0, ok}, {7'h0, val});
         rd_chk(1'b0, eprom_cfg_pkg::CFG1_XADDR, v, 1'b1, "x1");
         rd_chk(1'b0, eprom_cfg_pkg::CFG2_XADDR, ~v, 1'b1, "x2");
      end
      nv1 = 8'h00;
      nv2 = 8'h00;
      repeat (3) @(negedge mclk);
      cmp("frozen", 8'hff, cfg1);
   endtask

   task automatic t_program();
      logic [7:0] b;
      logic oe;
      pmode = 1'b1;
      repeat (2) @(negedge mclk);
      frame(eprom_cfg_pkg::CMD_WR_CODE, 16'h0123, 8'h5a);
      cmp("code", 8'h5a, mem[10'h123]);
      frame(eprom_cfg_pkg::CMD_WR_CODE, 16'hfce0, 8'hc7);
      frame(eprom_cfg_pkg::CMD_WR_CODE, 16'hfcff, 8'h3e);
      rd_chk(1'b1, 16'hfce0, 8'hc7, 1'b1, "cust lo");
      rd_chk(1'b1, 16'hfcff, 8'h3e, 1'b1, "cust hi");
      rd_chk(1'b1, 16'hfd00, 8'h00, 1'b0, "cust end");
      frame(eprom_cfg_pkg::CMD_WR_CFG1, 16'h0000, 8'hf3);
      nv1 = 8'hff;
      power_up();
      cmp("cfg1 prog", 8'hf3, cfg1);
      frame(eprom_cfg_pkg::CMD_RD_CODE, 16'h0123, 8'h00);
      host.read_byte(b, oe);
      cmp("verify", 8'h5a, b);
      cmp("verify oe", 8'h01, {7'h0, oe});
      cmp("refused", 8'h00, {7'h0, refused});
   endtask

   task automatic t_security();
      logic [7:0] b;
      logic oe;
      frame(eprom_cfg_pkg::CMD_WR_SB1, 16'h0000, 8'h00);
      cmp("sb1", 8'h00, {7'h0, sb1});
      frame(eprom_cfg_pkg::CMD_WR_CODE, 16'h0124, 8'h00);
      cmp("locked code", 8'hff, mem[10'h124]);
      cmp("refused wr", 8'h01, {7'h0, refused});
      // Second bit is accepted with or without the first one set
      frame(eprom_cfg_pkg::CMD_WR_SB2, 16'h0000, 8'h00);
      cmp("sb2", 8'h00, {7'h0, sb2});
      cmp("sb2 taken", 8'h00, {7'h0, refused});
      frame(eprom_cfg_pkg::CMD_RD_CODE, 16'h0123, 8'h00);
      cmp("refused rd", 8'h01, {7'h0, refused});
      host.read_byte(b, oe);
      cmp("locked oe", 8'h00, {7'h0, oe});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      rst_n = 1'b0;
      load = 1'b0;
      crd = 1'b0;
      xrd = 1'b0;
      pmode = 1'b0;
      nv1 = 8'hff;
      nv2 = 8'hff;
      addr = 16'h0000;
      for (int i = 0; i < 1024; i++)
         mem[i] = 8'hff;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      t_signature();
      t_config();
      t_program();
      t_security();
      summarize();
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      err_count++;
      summarize();
   end
endmodule
`default_nettype wire
